// ===== pkg/icf_map.svh
// register offsets, field positions, reset values and implemented-bit masks
`ifndef ICF_MAP_SVH
`define ICF_MAP_SVH

`define ICF_EXT_N        5
`define ICF_OFF_CTRL2    8'h00
`define ICF_OFF_FLAGS0   8'h04
`define ICF_OFF_FLAGS1   8'h08
`define ICF_OFF_FLAGS2   8'h0c
`define ICF_OFF_IRQ_STAT 8'h10
`define ICF_OFF_IRQ_MASK 8'h14

`define ICF_CTRL2_ALT_TABLE_BIT 15
`define ICF_CTRL2_DISINS_BIT 14
`define ICF_CTRL2_WR_MASK    16'h801f
`define ICF_CTRL2_RST        16'h0000

`define ICF_FLAGS0_IMPL  16'h7fff
`define ICF_FLAGS1_IMPL  16'hfffb
`define ICF_FLAGS2_IMPL  16'hdfff
`define ICF_FLAGS_RST    16'h0000

`define ICF_EXT0_BIT_F0  0
`define ICF_EXT1_BIT_F1  4
`define ICF_EXT2_BIT_F1  13

`define ICF_IRQ_BITS     3
`define ICF_IRQ_IMPL     3'h7
`define ICF_IRQ_RST      3'h0

`endif

// ===== pkg/icf_pkg.sv
// types shared by the interrupt flag and control block
package icf_pkg;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } icf_ahb_req_t;

  typedef struct packed {
    logic [15:0] lane2;
    logic [15:0] lane1;
    logic [15:0] lane0;
  } icf_req_t;

  typedef enum logic [2:0] {
    ICF_PH_IDLE  = 3'b001,
    ICF_PH_WRITE = 3'b010,
    ICF_PH_READ  = 3'b100
  } icf_phase_t;

endpackage

// ===== core/icf_ext_edge.sv
// synchroniser and selectable-polarity edge detector for external interrupt pins
`timescale 1ns/1ps
`include "icf_map.svh"
module icf_ext_edge
  import icf_pkg::*;
#(
  parameter int N = `ICF_EXT_N
) (
  input  wire logic         clk_sys_i,
  input  wire logic         arst_n_i,
  input  wire logic [N-1:0] pin_i,
  input  wire logic [N-1:0] falling_sel_i,
  output logic      [N-1:0] edge_o
);

  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] prev_r;
  logic [N-1:0] edge_r;
  logic [N-1:0] edge_nxt;

  // polarity change alone never fires: only a real transition of the pin counts
  always_comb begin
    edge_nxt = (falling_sel_i & prev_r & ~sync2_r) | (~falling_sel_i & ~prev_r & sync2_r);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
      edge_r  <= '0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      edge_r  <= edge_nxt;
    end
  end

  assign edge_o = edge_r;

endmodule

// ===== core/icf_regs.sv
// interrupt control register two and flag registers zero to two behind an AHB-Lite slave
// Function
// - bit 15 of control two selects the alternate vector table when set.
// - bit 14 of control two reads 1 while interrupt-disable instruction is active.
// - control two bits 13 to 5 read zero and ignore writes.
// - polarity bit 1 means falling edge request, 0 means rising edge.
// - flag bits latch requests, are software read/write, clear at power-on.
// - flags zero bit 15 reads zero; bits 14 to 8 latch their sources.
// - flags zero bits 7 to 0 latch timers, compares, captures, ext irq 0.
// - flags one bits 15 to 8 latch serial, ext irq 2, timers, compares.
// - flags one bits 7 to 3, 1 and 0 latch their sources.
// - flags one bit 2 reads zero and ignores writes.
// - flags two bit 13 reads zero; bits 15, 14, 12 to 8 latch.
// - flags two bits 7 to 3 latch captures, transfer channel 3, CAN event.
// - flags two bits 2 to 0 latch CAN receive and serial two requests.
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "icf_map.svh"
module icf_regs
  import icf_pkg::*;
#(
  parameter int EXT_N = `ICF_EXT_N
) (
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire icf_ahb_req_t     ahb_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  input  wire icf_req_t         req_i,
  input  wire logic [EXT_N-1:0] ext_irq_i,
  input  wire logic             irq_disable_instr_active_i,
  output logic                  alt_vector_table_o,
  output logic      [EXT_N-1:0] ext_irq_edge_o,
  output logic                  irq_o
);

  // set wins over a software write in the same cycle
  function automatic logic [15:0] upd_flag(input logic [15:0] cur, input logic [15:0] set,
                                           input logic we, input logic [15:0] wd,
                                           input logic [15:0] impl);
    logic [15:0] base;
    base = we ? wd : cur;
    return (base | set) & impl;
  endfunction

  icf_phase_t   phase_r;
  icf_phase_t   phase_nxt;
  logic [7:0]   addr_r;
  logic [7:0]   addr_nxt;
  logic [31:0]  rdata_r;
  logic [31:0]  rdata_nxt;

  logic [15:0]  ctrl_r;
  logic [15:0]  ctrl_nxt;
  logic [15:0]  flags0_r;
  logic [15:0]  flags0_nxt;
  logic [15:0]  flags1_r;
  logic [15:0]  flags1_nxt;
  logic [15:0]  flags2_r;
  logic [15:0]  flags2_nxt;
  logic [`ICF_IRQ_BITS-1:0] stat_r;
  logic [`ICF_IRQ_BITS-1:0] stat_nxt;
  logic [`ICF_IRQ_BITS-1:0] mask_r;
  logic [`ICF_IRQ_BITS-1:0] mask_nxt;

  logic         acc;
  logic         wr_act;
  logic [15:0]  wd16;
  logic         we_ctrl;
  logic         we_f0;
  logic         we_f1;
  logic         we_f2;
  logic         we_stat;
  logic         we_mask;
  logic [15:0]  set0;
  logic [15:0]  set1;
  logic [15:0]  set2;
  logic [15:0]  ext_f0;
  logic [15:0]  ext_f1;
  logic [EXT_N-1:0] ext_edge;
  logic [`ICF_IRQ_BITS-1:0] ev;
  logic [15:0]  ctrl_rd;

  icf_ext_edge #(
    .N (EXT_N)
  ) u_ext_edge (
    .clk_sys_i     (clk_sys_i),
    .arst_n_i      (arst_n_i),
    .pin_i         (ext_irq_i),
    .falling_sel_i (ctrl_r[EXT_N-1:0]),
    .edge_o        (ext_edge)
  );

  // ---- bus phase tracking
  always_comb begin
    acc       = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
    phase_nxt = phase_r;
    addr_nxt  = addr_r;
    if (ahb_i.hready) begin
      phase_nxt = ICF_PH_IDLE;
      if (acc) begin
        phase_nxt = ahb_i.hwrite ? ICF_PH_WRITE : ICF_PH_READ;
        addr_nxt  = ahb_i.haddr[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r <= ICF_PH_IDLE;
      addr_r  <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      addr_r  <= addr_nxt;
    end
  end

  // ---- write strobes, applied at the end of the data phase
  always_comb begin
    wr_act  = (phase_r == ICF_PH_WRITE);
    wd16    = ahb_i.hwdata[15:0];
    we_ctrl = wr_act && (addr_r == `ICF_OFF_CTRL2);
    we_f0   = wr_act && (addr_r == `ICF_OFF_FLAGS0);
    we_f1   = wr_act && (addr_r == `ICF_OFF_FLAGS1);
    we_f2   = wr_act && (addr_r == `ICF_OFF_FLAGS2);
    we_stat = wr_act && (addr_r == `ICF_OFF_IRQ_STAT);
    we_mask = wr_act && (addr_r == `ICF_OFF_IRQ_MASK);
  end

  // ---- request sources into flag set vectors
  always_comb begin
    ext_f0 = 16'h0000;
    ext_f1 = 16'h0000;
    ext_f0[`ICF_EXT0_BIT_F0] = ext_edge[0];
    ext_f1[`ICF_EXT1_BIT_F1] = ext_edge[1];
    ext_f1[`ICF_EXT2_BIT_F1] = ext_edge[2];
    // lanes feeding external-interrupt positions are ignored; the pins own them
    set0 = (req_i.lane0 & ~16'h0001 & `ICF_FLAGS0_IMPL) | ext_f0;
    set1 = (req_i.lane1 & ~16'h2010 & `ICF_FLAGS1_IMPL) | ext_f1;
    set2 = req_i.lane2 & `ICF_FLAGS2_IMPL;
  end

  // ---- control and flag registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (we_ctrl) begin
      ctrl_nxt = wd16 & `ICF_CTRL2_WR_MASK;
    end
    flags0_nxt = upd_flag(flags0_r, set0, we_f0, wd16, `ICF_FLAGS0_IMPL);
    flags1_nxt = upd_flag(flags1_r, set1, we_f1, wd16, `ICF_FLAGS1_IMPL);
    flags2_nxt = upd_flag(flags2_r, set2, we_f2, wd16, `ICF_FLAGS2_IMPL);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r   <= `ICF_CTRL2_RST;
      flags0_r <= `ICF_FLAGS_RST;
      flags1_r <= `ICF_FLAGS_RST;
      flags2_r <= `ICF_FLAGS_RST;
    end else begin
      ctrl_r   <= ctrl_nxt;
      flags0_r <= flags0_nxt;
      flags1_r <= flags1_nxt;
      flags2_r <= flags2_nxt;
    end
  end

  // ---- summary interrupt: one event per flag register gaining a new bit
  always_comb begin
    ev[0]    = |(set0 & ~flags0_r);
    ev[1]    = |(set1 & ~flags1_r);
    ev[2]    = |(set2 & ~flags2_r);
    stat_nxt = stat_r;
    if (we_stat) begin
      stat_nxt = stat_r & ~ahb_i.hwdata[`ICF_IRQ_BITS-1:0];
    end
    stat_nxt = (stat_nxt | ev) & `ICF_IRQ_IMPL;
    mask_nxt = mask_r;
    if (we_mask) begin
      mask_nxt = ahb_i.hwdata[`ICF_IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_r <= `ICF_IRQ_RST;
      mask_r <= `ICF_IRQ_RST;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ---- read data, sampled at the address phase from next values
  // reading next values lets a read right after a write see the written data
  always_comb begin
    ctrl_rd = ctrl_nxt;
    ctrl_rd[`ICF_CTRL2_DISINS_BIT] = irq_disable_instr_active_i;
    rdata_nxt = rdata_r;
    if (acc && !ahb_i.hwrite) begin
      unique case (ahb_i.haddr[7:0])
        `ICF_OFF_CTRL2:    rdata_nxt = {16'h0000, ctrl_rd};
        `ICF_OFF_FLAGS0:   rdata_nxt = {16'h0000, flags0_nxt};
        `ICF_OFF_FLAGS1:   rdata_nxt = {16'h0000, flags1_nxt};
        `ICF_OFF_FLAGS2:   rdata_nxt = {16'h0000, flags2_nxt};
        `ICF_OFF_IRQ_STAT: rdata_nxt = {29'h0000000, stat_nxt};
        `ICF_OFF_IRQ_MASK: rdata_nxt = {29'h0000000, mask_nxt};
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata_o           = rdata_r;
  assign hreadyout_o        = 1'b1;
  assign hresp_o            = 1'b0;
  assign alt_vector_table_o = ctrl_r[`ICF_CTRL2_ALT_TABLE_BIT];
  assign ext_irq_edge_o     = ext_edge;
  assign irq_o              = |(stat_r & mask_r);

  // ---- checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  a_alt_table_sel: assert property (we_ctrl |=> (alt_vector_table_o == $past(wd16[15])))
    else $error("vector table select does not follow write");

  a_instr_dis_readback: assert property ((acc && !ahb_i.hwrite && ahb_i.haddr[7:0] == `ICF_OFF_CTRL2)
                                         |=> (hrdata_o[14] == $past(irq_disable_instr_active_i)))
    else $error("instruction-disable status bit reads wrong");

  a_ctrl_unimpl: assert property ((ctrl_r[13:5] == 9'h000) && !ctrl_r[14])
    else $error("unimplemented control bits not zero");

  a_ext_edge_flag: assert property (($fell(ext_irq_i[0]) && ctrl_r[0] && $stable(ctrl_r[0]))
                                    |-> ##[1:5] flags0_r[0])
    else $error("falling edge did not flag external interrupt zero");

  a_flag_set_wins: assert property ((set0 != 16'h0000) |=> ((flags0_r & $past(set0)) == $past(set0)))
    else $error("request lost in flag register zero");

  a_unimpl_flags: assert property (!flags0_r[15] && !flags1_r[2] && !flags2_r[13])
    else $error("unimplemented flag bit set");

  a_f1_bit2_read: assert property ((acc && !ahb_i.hwrite && ahb_i.haddr[7:0] == `ICF_OFF_FLAGS1)
                                   |=> !hrdata_o[2])
    else $error("flags one bit two reads nonzero");

  a_f2_latch: assert property (req_i.lane2[2] |=> flags2_r[2] [*2] or (we_f2 ##0 1'b1))
    else $error("receive-ready flag not held");

  a_flag_holds: assert property ((flags1_r[13] && !we_f1) |=> flags1_r[13])
    else $error("external interrupt two flag dropped without a write");

  // status set wins over a clear, so a new event while fully unmasked must raise the line
  a_irq_level: assert property (((ev != 3'h0) && (mask_r == 3'h7) && !we_mask) |=> irq_o)
    else $error("interrupt output low after a new unmasked event");

  c_ctrl_write: cover property (we_ctrl ##1 alt_vector_table_o);
  c_flag_read:  cover property (acc && !ahb_i.hwrite ##1 hrdata_o != 32'h0);
  c_irq_rise:   cover property ($rose(irq_o));
  c_ext_edge:   cover property (ext_edge[2] ##1 flags1_r[13]);

endmodule

// ===== sim/icf_periph_model.sv
// peripheral request sources and core-side levels feeding the flag block
`timescale 1ns/1ps
module icf_periph_model
  import icf_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic       fire_i,
  input  wire icf_req_t   lanes_i,
  input  wire logic [4:0] pin_lvl_i,
  input  wire logic       dis_act_i,
  output icf_req_t        req_o,
  output logic      [4:0] ext_irq_o,
  output logic            dis_act_o
);
  // requests are single-cycle pulses so sticky latching is really exercised
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_o <= '0;
    end else begin
      req_o <= fire_i ? lanes_i : '0;
    end
  end
  assign ext_irq_o = pin_lvl_i;
  assign dis_act_o = dis_act_i;
endmodule

// ===== sim/icf_regs_tb.sv
// self-checking bench for the interrupt control and flag registers
`timescale 1ns/1ps
module icf_regs_tb;
  import icf_pkg::*;
  logic clk_sys_i;
  logic arst_n_i;
  logic hsel, hwrite, fire, dis_act;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata_o, rd;
  logic hreadyout_o, hresp_o, irq_o, alt_vector_table_o, dis_act_w;
  logic [4:0] pins, ext_w, ext_irq_edge_o;
  icf_req_t lanes, req_w;
  icf_ahb_req_t ahb;
  int err_count;
  int tests_run;
  typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] ex;} row_t;
  row_t rows [10] = '{'{8'h00, 32'h0000ffff, 32'h0000801f}, '{8'h00, 32'h00000000, 32'h00000000},
    '{8'h04, 32'h0000ffff, 32'h00007fff}, '{8'h08, 32'h0000ffff, 32'h0000fffb},
    '{8'h0c, 32'h0000ffff, 32'h0000dfff}, '{8'h04, 32'h00000000, 32'h00000000},
    '{8'h08, 32'h00000000, 32'h00000000}, '{8'h0c, 32'h00000000, 32'h00000000},
    '{8'h14, 32'h0000ffff, 32'h00000007}, '{8'h18, 32'h0000ffff, 32'h00000000}};

  assign ahb = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: hsize,
                 hwdata: hwdata, hready: hreadyout_o};

  icf_periph_model u_icf_periph_model (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .fire_i(fire),
    .lanes_i(lanes), .pin_lvl_i(pins), .dis_act_i(dis_act), .req_o(req_w), .ext_irq_o(ext_w),
    .dis_act_o(dis_act_w));

  icf_regs u_icf_regs (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ahb_i(ahb), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .req_i(req_w), .ext_irq_i(ext_w),
    .irq_disable_instr_active_i(dis_act_w), .alt_vector_table_o(alt_vector_table_o),
    .ext_irq_edge_o(ext_irq_edge_o), .irq_o(irq_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      err_count++;
    end
  endtask

  // address phase held until hready, then data phase held until hready again
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    rdv = hrdata_o;
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ex, input string nm);
    bus(1'b1, a, wd, rd);
    bus(1'b0, a, 32'h0, rd);
    chk(nm, ex, rd);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    bus(1'b0, a, 32'h0, rd);
    chk(nm, ex, rd);
  endtask

  task automatic pulse(input icf_req_t l);
    lanes <= l;
    fire  <= 1'b1;
    @(posedge clk_sys_i);
    fire  <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic close_out();
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run is about two hundred cycles; allow a wide margin
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_count++;
    close_out();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    arst_n_i = 1'b0;
    {hsel, hwrite, fire, dis_act} = 4'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    pins = 5'h00;
    lanes = '0;
    repeat (10) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int k = 0; k < 4; k++) rd_chk(8'(4 * k), 32'h0, "reset value");
    for (int i = 0; i < 10; i++) wr_rd(rows[i].a, rows[i].wd, rows[i].ex, "row readback");
    // core-side disable level and table select
    dis_act <= 1'b1;
    wr_rd(8'h00, 32'h0000c000, 32'h0000c000, "ctrl disable bit");
    chk("alt table out", 32'h1, {31'h0, alt_vector_table_o});
    dis_act <= 1'b0;
    wr_rd(8'h00, 32'h00000000, 32'h00000000, "ctrl cleared");
    chk("alt table out", 32'h0, {31'h0, alt_vector_table_o});
    // every source fires together; ext-owned positions only follow pins
    pulse('{lane2: 16'hffff, lane1: 16'hffff, lane0: 16'hffff});
    rd_chk(8'h04, 32'h00007ffe, "flags0 sources");
    rd_chk(8'h08, 32'h0000dfeb, "flags1 sources");
    rd_chk(8'h0c, 32'h0000dfff, "flags2 sources");
    rd_chk(8'h04, 32'h00007ffe, "flags0 sticky");
    for (int k = 1; k < 4; k++) wr_rd(8'(4 * k), 32'h0, 32'h0, "flag clear");
    // interrupt: raise masked, unmask, clear
    wr_rd(8'h14, 32'h0, 32'h0, "mask off");
    wr_rd(8'h10, 32'h7, 32'h0, "status w1c");
    pulse('{lane2: 16'h0000, lane1: 16'h0000, lane0: 16'h0020});
    rd_chk(8'h10, 32'h1, "status set");
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wr_rd(8'h14, 32'h1, 32'h1, "mask on");
    chk("irq unmasked", 32'h1, {31'h0, irq_o});
    wr_rd(8'h10, 32'h1, 32'h0, "status cleared");
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    wr_rd(8'h04, 32'h0, 32'h0, "flags0 clear");
    // pin 0 rising-sensitive, pin 1 falling-sensitive
    wr_rd(8'h00, 32'h00000002, 32'h00000002, "polarity select");
    pins <= 5'h03;
    repeat (8) @(posedge clk_sys_i);
    rd_chk(8'h04, 32'h00000001, "ext0 rising");
    rd_chk(8'h08, 32'h00000000, "ext1 no rise");
    pins <= 5'h00;
    repeat (8) @(posedge clk_sys_i);
    rd_chk(8'h08, 32'h00000010, "ext1 falling");
    rd_chk(8'h04, 32'h00000001, "ext0 held");
    // pin 0 falling-sensitive, pins 2 to 4 rising; edge pulses of all pins watched
    wr_rd(8'h04, 32'h0, 32'h0, "flags0 clear");
    wr_rd(8'h08, 32'h0, 32'h0, "flags1 clear");
    wr_rd(8'h00, 32'h00000001, 32'h00000001, "polarity select two");
    pins <= 5'h1d;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("edge pulse", 32'h0000001c, {27'h0, ext_irq_edge_o});
    @(negedge clk_sys_i);
    chk("edge pulse ends", 32'h0, {27'h0, ext_irq_edge_o});
    repeat (4) @(posedge clk_sys_i);
    rd_chk(8'h08, 32'h00002000, "ext2 rising");
    rd_chk(8'h04, 32'h00000000, "ext0 no rise");
    pins <= 5'h00;
    repeat (8) @(posedge clk_sys_i);
    rd_chk(8'h04, 32'h00000001, "ext0 falling");
    rd_chk(8'h08, 32'h00002000, "ext2 held");
    // second reset in mid-run clears everything again
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk("irq after reset", 32'h0, {31'h0, irq_o});
    chk("alt table after reset", 32'h0, {31'h0, alt_vector_table_o});
    rd_chk(8'h04, 32'h0, "flags0 after reset");
    rd_chk(8'h08, 32'h0, "flags1 after reset");
    rd_chk(8'h00, 32'h0, "ctrl after reset");
    chk("bus ready", 32'h1, {31'h0, hreadyout_o});
    chk("bus response", 32'h0, {31'h0, hresp_o});
    close_out();
  end
endmodule
